// ---- logic/swc_sleep_ctrl.sv ----
`include "swc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module swc_sleep_ctrl #(
  parameter int WDT_CYCLES = `SWC_WDT_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire swc_pkg::swc_cpu_req_t cpu_req,
  input wire logic [10:0] pc,
  input wire logic master_clear_pin_n,
  input wire logic ext_irq_pin,
  input wire logic [3:0] upper_port_pin,
  input wire logic second_timer_ovf,
  input wire logic second_timer_async,
  input wire logic [4:0] periph_wake_irq,
  input wire logic core_timer_ovf,
  input wire logic [7:0] io_out,
  input wire logic [7:0] io_oe,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output swc_pkg::swc_seq_t seq,
  output logic [10:0] prefetch_addr,
  output logic [10:0] ret_addr
);

  localparam int NI = `SWC_IRQ_N;
  localparam logic [10:0] OST_LAST = 11'(`SWC_OST_CYCLES - 1);
  localparam logic [31:0] WDT_LAST = 32'(WDT_CYCLES - 1);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic master_clear_pin_n_s;
  logic ext_s;
  logic [3:0] port_s;

  swc_sync #(.W(1), .INIT(1'b1)) u_sync_master_clear_pin (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(master_clear_pin_n),
    .q(master_clear_pin_n_s)
  );

  swc_sync #(.W(5), .INIT(5'h00)) u_sync_irq (
    .clk(clk),
    .sys_rst(sys_rst),
    .d({upper_port_pin, ext_irq_pin}),
    .q({port_s, ext_s})
  );

  // ****************************************
  // State
  // ****************************************
  swc_pkg::swc_state_t state_r, state_nxt;
  logic [2:0] ctrl_r;
  logic [NI-1:0] en_r, flag_r, flag_nxt;
  logic pd_r, to_r, ext_d_r, wake_irq_r, defer_r;
  logic [3:0] port_d_r;
  logic [31:0] wdt_cnt_r;
  logic [10:0] ost_cnt_r;
  swc_pkg::swc_seq_t seq_r;
  logic [15:0] rdata_r;
  logic [7:0] pin_out_r, pin_oe_r;
  logic [10:0] prefetch_r, ret_r;

  // ****************************************
  // Decode and events
  // ****************************************
  wire awake = (state_r == swc_pkg::swc_run);
  wire master_clear_pin_evt = ~master_clear_pin_n_s;
  wire global_irq_enable = ctrl_r[`SWC_CTRL_GIE];
  wire rc_mode = ctrl_r[`SWC_CTRL_RC_OSC];
  wire wr_ctrl = reg_wr && (reg_addr == `SWC_ADDR_CTRL);
  wire wr_en = reg_wr && (reg_addr == `SWC_ADDR_IRQ_EN);
  wire wr_flag = reg_wr && (reg_addr == `SWC_ADDR_IRQ_FLAG);

  // Edge on interrupt pin, any change on upper port
  wire ext_rise = ext_s & ~ext_d_r;
  wire port_chg = |(port_s ^ port_d_r);

  // Event vector; clocked sources gated while asleep
  wire [NI-1:0] ev = {
    core_timer_ovf & awake,
    periph_wake_irq,
    second_timer_ovf & (second_timer_async | awake),
    port_chg,
    ext_rise
  };

  // Pending uses only individual enables
  wire pend = |(flag_r & en_r);
  wire sleep_req = awake && cpu_req.sleep_exec && !master_clear_pin_evt;
  wire sleep_full = sleep_req && !pend;

  // Watchdog
  wire wdt_en = ctrl_r[`SWC_CTRL_WDT_EN];
  wire wdt_clr = cpu_req.wdt_clear || sleep_full;
  wire wdt_to = wdt_en && (wdt_cnt_r == WDT_LAST);
  wire wdt_wake = wdt_to && (state_r == swc_pkg::swc_sleep);
  wire wdt_rst = wdt_to && !wdt_clr && (state_r != swc_pkg::swc_sleep);

  // Wake cause while asleep
  wire wake_evt = pend || wdt_wake;
  wire ost_done = rc_mode || (ost_cnt_r == OST_LAST);
  wire irq_go = awake && global_irq_enable && pend && !defer_r && !seq_r.irq_take;

  // Flags: set beats software clear
  assign flag_nxt = (flag_r & ~(wr_flag ? reg_wdata[NI-1:0] : {NI{1'b0}})) | ev;

  // Read data mux
  wire [15:0] rd_mux =
    (reg_addr == `SWC_ADDR_CTRL) ? {13'h0000, ctrl_r} :
    (reg_addr == `SWC_ADDR_IRQ_EN) ? {7'h00, en_r} :
    (reg_addr == `SWC_ADDR_IRQ_FLAG) ? {7'h00, flag_r} :
    (reg_addr == `SWC_ADDR_STATUS) ? {11'h000, to_r, pd_r, 1'b0,
      state_r == swc_pkg::swc_start, state_r == swc_pkg::swc_sleep} :
    16'h0000;

  // ****************************************
  // Sleep sequencer
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      swc_pkg::swc_run: begin
        if (sleep_full) begin
          state_nxt = swc_pkg::swc_sleep;
        end
      end
      swc_pkg::swc_sleep: begin
        if (wake_evt) begin
          state_nxt = swc_pkg::swc_start;
        end
      end
      swc_pkg::swc_start: begin
        if (ost_done) begin
          state_nxt = swc_pkg::swc_run;
        end
      end
      default: state_nxt = swc_pkg::swc_run;
    endcase
    if (master_clear_pin_evt) begin
      state_nxt = swc_pkg::swc_run;
    end
  end

  // State, start-up count and held wake cause
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= swc_pkg::swc_run;
      ost_cnt_r <= 11'h000;
      wake_irq_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ost_cnt_r <= (state_r == swc_pkg::swc_start) ? ost_cnt_r + 11'h001 : 11'h000;
      if (state_r == swc_pkg::swc_sleep && wake_evt) begin
        wake_irq_r <= pend;
      end
    end
  end

  // Watchdog counter runs in every state
  always_ff @(posedge clk) begin
    if (sys_rst || wdt_clr || wdt_to || !wdt_en) begin
      wdt_cnt_r <= 32'h00000000;
    end else begin
      wdt_cnt_r <= wdt_cnt_r + 32'h00000001;
    end
  end

  // ****************************************
  // Status and control registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pd_r <= 1'b1;
      to_r <= 1'b1;
    end else begin
      if (sleep_full) begin
        pd_r <= 1'b0;
      end else if (cpu_req.wdt_clear) begin
        pd_r <= 1'b1;
      end
      if (wdt_to && !wdt_clr) begin
        to_r <= 1'b0;
      end else if (wdt_clr) begin
        to_r <= 1'b1;
      end
    end
  end

  // Control, enables and flags; response clears global enable
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r <= `SWC_CTRL_RST;
      en_r <= '0;
      flag_r <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= reg_wdata[2:0];
      end
      if (irq_go) begin
        ctrl_r[`SWC_CTRL_GIE] <= 1'b0;
      end
      if (wr_en) begin
        en_r <= reg_wdata[NI-1:0];
      end
      flag_r <= flag_nxt;
    end
  end

  // Pin history for edge and change detection
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_d_r <= 1'b0;
      port_d_r <= 4'h0;
    end else begin
      ext_d_r <= ext_s;
      port_d_r <= port_s;
    end
  end

  // ****************************************
  // Outputs to the sequencer
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seq_r <= '{osc_run: 1'b1, default: '0};
      defer_r <= 1'b0;
      prefetch_r <= 11'h000;
      ret_r <= 11'h000;
    end else begin
      seq_r.osc_run <= (state_nxt != swc_pkg::swc_sleep);
      seq_r.resume <= (state_r == swc_pkg::swc_start) && ost_done && !master_clear_pin_evt;
      seq_r.vector_after <= (state_r == swc_pkg::swc_start) && ost_done && wake_irq_r && global_irq_enable;
      seq_r.irq_take <= irq_go;
      seq_r.load_addr <= irq_go ? `SWC_IRQ_VECTOR : 11'h000;
      seq_r.dev_reset <= master_clear_pin_evt || wdt_rst;
      if ((state_r == swc_pkg::swc_start) && ost_done && !master_clear_pin_evt) begin
        defer_r <= 1'b1;
      end else if (cpu_req.instr_done) begin
        defer_r <= 1'b0;
      end
      if (cpu_req.sleep_exec) begin
        prefetch_r <= pc + 11'h001;
      end
      if (irq_go) begin
        ret_r <= pc;
      end
    end
  end

  // Pins frozen unless running
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_out_r <= 8'h00;
      pin_oe_r <= 8'h00;
    end else if (awake) begin
      pin_out_r <= io_out;
      pin_oe_r <= io_oe;
    end
  end

  // Register read, data valid the cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  assign reg_rdata = rdata_r;
  assign seq = seq_r;
  assign pin_out = pin_out_r;
  assign pin_oe = pin_oe_r;
  assign prefetch_addr = prefetch_r;
  assign ret_addr = ret_r;

  // ****************************************
  // Checks
  // ****************************************
  property p_sleep_stops_osc;
    @(posedge clk) disable iff (sys_rst) sleep_full |=> !seq_r.osc_run && !pd_r;
  endproperty
  a_sleep_stops_osc: assert property (p_sleep_stops_osc) else $error("osc or pd wrong after sleep");

  property p_nop_sleep;
    @(posedge clk) disable iff (sys_rst) sleep_req && pend && !cpu_req.wdt_clear |=> awake && $stable(pd_r);
  endproperty
  a_nop_sleep: assert property (p_nop_sleep) else $error("pending sleep did not act as no-op");

  property p_to_clear;
    @(posedge clk) disable iff (sys_rst || master_clear_pin_evt) wdt_wake |=> !to_r && (state_r == swc_pkg::swc_start);
  endproperty
  a_to_clear: assert property (p_to_clear) else $error("watchdog wake mishandled");

  property p_wdt_reset;
    @(posedge clk) disable iff (sys_rst) wdt_rst |=> seq_r.dev_reset && !seq_r.resume;
  endproperty
  a_wdt_reset: assert property (p_wdt_reset) else $error("running time-out gave no reset");

  // Cycles spent in start-up, for the delay check
  logic [10:0] start_len_r;
  always_ff @(posedge clk) begin
    if (sys_rst || state_r != swc_pkg::swc_start) begin
      start_len_r <= 11'h000;
    end else begin
      start_len_r <= start_len_r + 11'h001;
    end
  end

  property p_ost;
    @(posedge clk) disable iff (sys_rst || master_clear_pin_evt)
      seq_r.resume && !$past(rc_mode) |-> $past(start_len_r) == OST_LAST;
  endproperty
  a_ost: assert property (p_ost) else $error("start-up delay wrong");

  property p_vector;
    @(posedge clk) disable iff (sys_rst) seq_r.irq_take |-> seq_r.load_addr == `SWC_IRQ_VECTOR && !global_irq_enable;
  endproperty
  a_vector: assert property (p_vector) else $error("interrupt response wrong");

  property p_flag_set;
    @(posedge clk) disable iff (sys_rst) |ev |=> ((flag_r & $past(ev)) == $past(ev));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event flag lost");

  property p_pin_hold;
    @(posedge clk) disable iff (sys_rst) !awake |=> $stable(pin_out_r) && $stable(pin_oe_r);
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pins moved while asleep");

  property p_wake_no_gie;
    @(posedge clk) disable iff (sys_rst) (state_r == swc_pkg::swc_sleep) && pend && !master_clear_pin_evt
      |=> state_r == swc_pkg::swc_start;
  endproperty
  a_wake_no_gie: assert property (p_wake_no_gie) else $error("enabled interrupt did not wake");

endmodule

`default_nettype wire

// ---- logic/swc_params.svh ----
`ifndef SWC_PARAMS_SVH
`define SWC_PARAMS_SVH

// ****************************************
// Register map
// ****************************************
`define SWC_ADDR_CTRL 4'h0
`define SWC_ADDR_IRQ_EN 4'h1
`define SWC_ADDR_IRQ_FLAG 4'h2
`define SWC_ADDR_STATUS 4'h3

// ****************************************
// Field positions and reset values
// ****************************************
`define SWC_CTRL_WDT_EN 0
`define SWC_CTRL_RC_OSC 1
`define SWC_CTRL_GIE 2
`define SWC_CTRL_RST 3'h1
`define SWC_STAT_SLEEP 0
`define SWC_STAT_START 1
`define SWC_STAT_PD 3
`define SWC_STAT_TO 4

// ****************************************
// Interrupt sources
// ****************************************
`define SWC_IRQ_N 9
`define SWC_SRC_EXT 0
`define SWC_SRC_PORT 1
`define SWC_SRC_TMR2 2
`define SWC_SRC_CORE_TMR 8
`define SWC_IRQ_VECTOR 11'h004

// ****************************************
// Timing
// ****************************************
`define SWC_OST_TOSC 1024
`define SWC_TOSC_PS 4000
`define SWC_CLK_PS 4000
`define SWC_OST_CYCLES ((`SWC_OST_TOSC * `SWC_TOSC_PS + `SWC_CLK_PS - 1) / `SWC_CLK_PS)
`define SWC_WDT_CYCLES 65536

`endif

// ---- logic/swc_pkg.sv ----
package swc_pkg;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    swc_run = 2'b00,
    swc_sleep = 2'b01,
    swc_start = 2'b10
  } swc_state_t;

  // Requests from the CPU instruction sequencer
  typedef struct packed {
    logic sleep_exec;
    logic wdt_clear;
    logic instr_done;
  } swc_cpu_req_t;

  // Answers to the CPU instruction sequencer
  typedef struct packed {
    logic osc_run;
    logic resume;
    logic vector_after;
    logic irq_take;
    logic dev_reset;
    logic [10:0] load_addr;
  } swc_seq_t;

endpackage

// ---- logic/swc_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for pins
module swc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_r <= INIT;
      q <= INIT;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

`default_nettype wire

// ---- bench/swc_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ****************
// Sequencer stand-in
// ****************
module swc_cpu_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sleep_cmd,
  input wire logic resume,
  output swc_pkg::swc_cpu_req_t req,
  output logic [10:0] pc
);
  // Clear watchdog, then sleep, then retire the prefetched no-op
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req <= '0;
      pc <= 11'h010;
    end else begin
      req.wdt_clear <= sleep_cmd;
      req.sleep_exec <= req.wdt_clear;
      req.instr_done <= resume;
      if (req.sleep_exec || req.instr_done) begin
        pc <= pc + 11'h001;
      end
    end
  end
endmodule

`default_nettype wire

// ---- bench/sleep_wakeup_control_tb.sv ----
`include "swc_params.svh"
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp=%0h got=%0h", nm, e, g); end end

module sleep_wakeup_control_tb;
  logic clk, sys_rst, reg_wr, reg_rd, sleep_cmd, clear_n, ext_irq, st_ovf, st_async, core_ovf;
  logic rd_d = 1'b0;
  logic [3:0] reg_addr, up_pin;
  logic [4:0] pw_irq;
  logic [7:0] io_out, io_oe, pin_out, pin_oe, io_s;
  logic [10:0] pc, pf, prefetch_addr, ret_addr;
  logic [15:0] reg_wdata, reg_rdata, ev;
  logic [15:0] exp_q[$];
  swc_pkg::swc_cpu_req_t req;
  swc_pkg::swc_seq_t seq;
  int err_total = 0;
  int checks = 0;
  int n, b;

  swc_sleep_ctrl #(.WDT_CYCLES(64)) DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_req(req),
    .pc(pc), .master_clear_pin_n(clear_n), .ext_irq_pin(ext_irq), .upper_port_pin(up_pin),
    .second_timer_ovf(st_ovf), .second_timer_async(st_async), .periph_wake_irq(pw_irq),
    .core_timer_ovf(core_ovf), .io_out(io_out), .io_oe(io_oe), .pin_out(pin_out), .pin_oe(pin_oe),
    .seq(seq), .prefetch_addr(prefetch_addr), .ret_addr(ret_addr));

  swc_cpu_model cpu (.clk(clk), .sys_rst(sys_rst), .sleep_cmd(sleep_cmd), .resume(seq.resume),
    .req(req), .pc(pc));

  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ****************
  // Bus and sequencing tasks
  // ****************
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  task slp;
    pf = pc + 11'h001;
    @(posedge clk);
    sleep_cmd <= 1'b1;
    @(posedge clk);
    sleep_cmd <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task waitr(input int lim);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (seq.resume !== 1'b1 && n < lim);
  endtask

  task tally_and_finish;
    $display("checks=%0d errors=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Read data checked in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d) begin
      ev = exp_q.pop_front();
      `CHK("reg_rdata", ev, reg_rdata)
    end
    rd_d <= reg_rd;
  end

  // Hang guard
  initial begin
    repeat (8000) @(posedge clk);
    err_total++;
    tally_and_finish;
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    void'($urandom(32'h1E9DF876));
    {sys_rst, clear_n} = 2'b11;
    {reg_wr, reg_rd, sleep_cmd, ext_irq, st_ovf, st_async, core_ovf} = '0;
    {reg_addr, up_pin, pw_irq, io_out, io_oe, reg_wdata} = '0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`SWC_ADDR_CTRL, 16'h0001);
    rd(`SWC_ADDR_STATUS, 16'h0018);
    wr(4'hF, 16'hFFFF);
    rd(4'hF, 16'h0000);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (seq.dev_reset !== 1'b1 && n < 100);
    `CHK("wdt_run_reset", 1'b1, seq.dev_reset)
    rd(`SWC_ADDR_STATUS, 16'h0008);
    // Interrupt wake, RC mode, global enable off
    wr(`SWC_ADDR_CTRL, 16'h0002);
    wr(`SWC_ADDR_IRQ_EN, 16'h0001);
    io_s = $urandom;
    io_out <= io_s;
    io_oe <= ~io_s;
    repeat (2) @(posedge clk);
    slp;
    `CHK("prefetch", pf, prefetch_addr)
    `CHK("osc_off", 1'b0, seq.osc_run)
    rd(`SWC_ADDR_STATUS, 16'h0011);
    io_out <= ~io_s;
    io_oe <= io_s;
    up_pin <= 4'h5;
    core_ovf <= 1'b1;
    st_ovf <= 1'b1;
    @(posedge clk);
    core_ovf <= 1'b0;
    st_ovf <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    `CHK("pin_out", io_s, pin_out)
    `CHK("pin_oe", ~io_s, pin_oe)
    `CHK("still_asleep", 1'b0, seq.osc_run)
    ext_irq <= 1'b1;
    waitr(20);
    `CHK("rc_wake", 1'b1, seq.resume)
    `CHK("vector_off", 1'b0, seq.vector_after)
    rd(`SWC_ADDR_IRQ_FLAG, 16'h0003);
    // Enabled flag already pending
    slp;
    `CHK("no_sleep", 1'b1, seq.osc_run)
    rd(`SWC_ADDR_STATUS, 16'h0018);
    ext_irq <= 1'b0;
    // Peripheral wake, crystal mode, global enable on
    wr(`SWC_ADDR_IRQ_FLAG, 16'h01FF);
    wr(`SWC_ADDR_CTRL, 16'h0004);
    b = 3 + $urandom_range(4);
    wr(`SWC_ADDR_IRQ_EN, 16'h0001 << b);
    slp;
    pw_irq[b-3] <= 1'b1;
    @(posedge clk);
    pw_irq <= '0;
    waitr(1100);
    `CHK("ost_wake", 1'b1, seq.resume === 1'b1 && n >= 1024)
    `CHK("vector_on", 1'b1, seq.vector_after)
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (seq.irq_take !== 1'b1 && n < 8);
    `CHK("vec_addr", 11'h004, seq.load_addr)
    `CHK("ret_addr", pf + 11'h001, ret_addr)
    rd(`SWC_ADDR_CTRL, 16'h0000);
    // Watchdog wake
    wr(`SWC_ADDR_IRQ_EN, 16'h0000);
    wr(`SWC_ADDR_CTRL, 16'h0003);
    slp;
    waitr(200);
    `CHK("wdt_wake", 1'b1, seq.resume)
    `CHK("wdt_no_reset", 1'b0, seq.dev_reset)
    rd(`SWC_ADDR_STATUS, 16'h0000);
    wr(`SWC_ADDR_CTRL, 16'h0002);
    // Master clear
    clear_n <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    `CHK("clear_reset", 1'b1, seq.dev_reset)
    clear_n <= 1'b1;
    repeat (6) @(posedge clk);
    tally_and_finish;
  end
endmodule

`default_nettype wire
